// ### design/cac_pkg.sv
// Register map, field layout, timing and types of the calendar alarm.
// How it works
// RL1 - Minute alarm is BCD in bits 6..0.
// RL2 - Unassigned alarm bits are plain storage only.
// RL3 - Alarm registers stay usable storage while disabled.
// RL4 - Hour bit 5 is meridiem or twenty digit.
// RL5 - Hour code 32 follows eleven PM, compared alike.
// RL6 - Day bit 7 enables day; bits 5..0 BCD.
// RL7 - Month BCD bits 4..0, enable in bit 7.
// RL8 - Month/day enable pair selects the compared fields.
// RL9 - Flag sets on match only while enabled.
// RL10 - Flag reads zero while alarm is disabled.
// RL11 - Flag stays set until software clears it.
// RL12 - Writing zero clears flag, releases pin; one ignored.
// RL13 - Power-on detection zeroes all four alarm registers.
// RL14 - Flag rises 61 us after match, pin low.
// RL15 - Already matching time fires only on next arrival.
// RL16 - Software disables, sets time, clears flag, enables.
// RL17 - All enabled fields equal at counter update.
package cac_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned ALARM_DLY_US = 61;
   localparam int unsigned ALARM_DLY_CYC = ALARM_DLY_US * CLK_MHZ;
   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_ALM_B = 6'h0B;
   localparam logic [5:0] IDX_ALM_C = 6'h0C;
   localparam logic [5:0] IDX_CTRL1 = 6'h0E;
   localparam logic [5:0] IDX_CTRL2 = 6'h0F;
   localparam logic [5:0] IDX_IRQ_STS = 6'h10;
   localparam logic [5:0] IDX_IRQ_MSK = 6'h11;
   localparam int unsigned C1_ALARM_EN = 6;
   localparam int unsigned C2_BANK = 7;
   localparam int unsigned C2_PON = 4;
   localparam int unsigned C2_FLAG = 0;
   localparam int unsigned MATCH_EN = 7;
   localparam int unsigned IRQ_ALARM = 0;
   localparam logic [7:0] MIN_MSK = 8'h7F;
   localparam logic [7:0] HOUR_MSK = 8'h3F;
   localparam logic [7:0] DAY_MSK = 8'h3F;
   localparam logic [7:0] MON_MSK = 8'h1F;
   localparam logic [7:0] RST_ALARM = 8'h00;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_IRQ = 8'h00;
   typedef struct packed {
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] minute;
   } cac_time_t;
endpackage

// ### design/cac_compare.sv
// Field comparison between alarm registers and running time counters.
`timescale 1ns/1ps
module cac_compare (
   input wire cac_pkg::cac_time_t alarm, // alarm register contents
   input wire cac_pkg::cac_time_t now, // running counters
   output logic match // all enabled fields equal
);
   logic hit_min;
   logic hit_hour;
   logic hit_day;
   logic hit_mon;

   always_comb
   begin
      hit_min = ((alarm.minute ^ now.minute) & cac_pkg::MIN_MSK) == 8'h00; // RL1 RL2
      // The counter jumps to code 32 after eleven PM, so raw bits compare.
      hit_hour = ((alarm.hour ^ now.hour) & cac_pkg::HOUR_MSK) == 8'h00; // RL4 RL5
      hit_day = !alarm.day[cac_pkg::MATCH_EN]
         || (((alarm.day ^ now.day) & cac_pkg::DAY_MSK) == 8'h00); // RL6
      hit_mon = !alarm.month[cac_pkg::MATCH_EN]
         || (((alarm.month ^ now.month) & cac_pkg::MON_MSK) == 8'h00); // RL7
      match = hit_min && hit_hour && hit_day && hit_mon; // RL8 RL17
   end
endmodule // cac_compare

// ### design/cac_delay.sv
// One-shot delay between an alarm match and the flag rising.
`timescale 1ns/1ps
module cac_delay #(
   parameter int unsigned DLY = 12200
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic start, // match pulse
   input wire logic abort, // alarm disabled
   output logic done // one-cycle pulse after DLY cycles
);
   localparam int unsigned W = $clog2(DLY + 1);
   localparam logic [W-1:0] LAST = W'(DLY - 1);
   logic busy_ff;
   logic [W-1:0] cnt_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
      end
      else if (abort)
      begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
      end
      else if (start)
      begin
         busy_ff <= 1'b1;
         cnt_ff <= '0;
      end
      else if (busy_ff && cnt_ff == LAST)
      begin
         busy_ff <= 1'b0;
      end
      else if (busy_ff)
      begin
         cnt_ff <= cnt_ff + 1'b1; // RL14
      end
   end

   assign done = busy_ff && cnt_ff == LAST && !abort && !start; // RL14

   a_count_steps: assert property (@(posedge pclk) disable iff (!presetn)
      busy_ff && !start && !abort && cnt_ff != LAST |=> cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("Delay counter skipped a step."); // RL14
endmodule // cac_delay

// ### design/cac_alarm_top.sv
// APB register file, match detection, sticky flag and interrupt pin of the alarm.
`timescale 1ns/1ps
module cac_alarm_top #(
   parameter int unsigned DLY_CYCLES = cac_pkg::ALARM_DLY_CYC
) (
   input wire logic pclk, // clock, 200 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire cac_pkg::cac_time_t now, // running time counters
   input wire logic time_upd, // counters just updated
   input wire logic por_set, // power-on detection pulse
   output logic irq_a_pin_o, // open-drain pin value
   output logic irq_a_pin_oe, // pin driven low while high
   output logic irq // level interrupt
);
   logic [7:0] alm_min_ff;
   logic [7:0] alm_hour_ff;
   logic [7:0] alm_day_ff;
   logic [7:0] alm_mon_ff;
   logic [7:0] ctrl1_ff;
   logic bank_ff;
   logic pon_ff;
   logic flag_ff;
   logic [7:0] sts_ff;
   logic [7:0] msk_ff;
   logic prev_match_ff;
   logic [31:0] rdata_ff;
   logic [5:0] idx;
   logic aligned;
   logic mapped;
   logic wr_en;
   logic [7:0] wbyte;
   logic alarm_en;
   logic match;
   logic match_edge;
   logic dly_done;
   logic flag_clr;
   logic nxt_flag;
   logic [7:0] nxt_sts;
   logic [7:0] rd_mux;
   cac_pkg::cac_time_t alarm;

   assign idx = paddr[7:2];
   assign aligned = paddr[1:0] == 2'b00;
   assign mapped = aligned && (idx == cac_pkg::IDX_ALM_B || idx == cac_pkg::IDX_ALM_C
      || idx == cac_pkg::IDX_CTRL1 || idx == cac_pkg::IDX_CTRL2
      || idx == cac_pkg::IDX_IRQ_STS || idx == cac_pkg::IDX_IRQ_MSK);
   assign wr_en = psel && penable && pwrite && pstrb[0] && mapped;
   assign wbyte = pwdata[7:0];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_ff;
   assign alarm_en = ctrl1_ff[cac_pkg::C1_ALARM_EN];

   // Bank-switched alarm registers stay plain storage even when disabled.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alm_min_ff <= cac_pkg::RST_ALARM;
         alm_hour_ff <= cac_pkg::RST_ALARM;
         alm_day_ff <= cac_pkg::RST_ALARM;
         alm_mon_ff <= cac_pkg::RST_ALARM;
      end
      else if (por_set)
      begin
         alm_min_ff <= cac_pkg::RST_ALARM; // RL13
         alm_hour_ff <= cac_pkg::RST_ALARM; // RL13
         alm_day_ff <= cac_pkg::RST_ALARM; // RL13
         alm_mon_ff <= cac_pkg::RST_ALARM; // RL13
      end
      else if (wr_en && idx == cac_pkg::IDX_ALM_B)
      begin
         if (!bank_ff)
            alm_min_ff <= wbyte; // RL1 RL2 RL3
         else
            alm_day_ff <= wbyte; // RL6 RL3
      end
      else if (wr_en && idx == cac_pkg::IDX_ALM_C)
      begin
         if (!bank_ff)
            alm_hour_ff <= wbyte; // RL4 RL3
         else
            alm_mon_ff <= wbyte; // RL7 RL3
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl1_ff <= cac_pkg::RST_CTRL1;
      else if (por_set)
         ctrl1_ff <= cac_pkg::RST_CTRL1;
      else if (wr_en && idx == cac_pkg::IDX_CTRL1)
         ctrl1_ff <= wbyte;
   end

   // Bank select and power-on indication; the indication clears on a zero write.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bank_ff <= 1'b0;
         pon_ff <= 1'b0;
      end
      else if (por_set)
      begin
         bank_ff <= 1'b0;
         pon_ff <= 1'b1;
      end
      else if (wr_en && idx == cac_pkg::IDX_CTRL2)
      begin
         bank_ff <= wbyte[cac_pkg::C2_BANK];
         pon_ff <= pon_ff && wbyte[cac_pkg::C2_PON];
      end
   end

   assign alarm.minute = alm_min_ff;
   assign alarm.hour = alm_hour_ff;
   assign alarm.day = alm_day_ff;
   assign alarm.month = alm_mon_ff;

   cac_compare u_cmp (
      .alarm(alarm),
      .now(now),
      .match(match)
   );

   // Only a transition into equality fires, so a time already equal waits.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_match_ff <= 1'b0;
      else if (time_upd)
         prev_match_ff <= match; // RL15
   end

   assign match_edge = time_upd && match && !prev_match_ff && alarm_en; // RL15 RL17 RL9

   cac_delay #(
      .DLY(DLY_CYCLES)
   ) u_dly (
      .pclk(pclk),
      .presetn(presetn),
      .start(match_edge),
      .abort(!alarm_en),
      .done(dly_done)
   );

   assign flag_clr = wr_en && idx == cac_pkg::IDX_CTRL2 && !wbyte[cac_pkg::C2_FLAG]; // RL12

   always_comb
   begin
      nxt_flag = flag_ff;
      if (flag_clr)
         nxt_flag = 1'b0; // RL12
      if (dly_done)
         nxt_flag = 1'b1; // RL9 RL14
      if (!alarm_en || por_set)
         nxt_flag = 1'b0; // RL10
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_ff <= 1'b0;
      else
         flag_ff <= nxt_flag; // RL11
   end

   assign irq_a_pin_o = 1'b0;
   assign irq_a_pin_oe = flag_ff; // RL14 RL12

   always_comb
   begin
      nxt_sts = sts_ff;
      if (wr_en && idx == cac_pkg::IDX_IRQ_STS)
         nxt_sts = sts_ff & ~wbyte;
      nxt_sts[cac_pkg::IRQ_ALARM] = nxt_sts[cac_pkg::IRQ_ALARM] || dly_done;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sts_ff <= cac_pkg::RST_IRQ;
      else
         sts_ff <= nxt_sts;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         msk_ff <= cac_pkg::RST_IRQ;
      else if (wr_en && idx == cac_pkg::IDX_IRQ_MSK)
         msk_ff <= wbyte;
   end

   assign irq = |(sts_ff & msk_ff);

   always_comb
   begin
      rd_mux = 8'h00;
      unique case (idx)
         cac_pkg::IDX_ALM_B: rd_mux = bank_ff ? alm_day_ff : alm_min_ff;
         cac_pkg::IDX_ALM_C: rd_mux = bank_ff ? alm_mon_ff : alm_hour_ff;
         cac_pkg::IDX_CTRL1: rd_mux = ctrl1_ff;
         cac_pkg::IDX_CTRL2:
         begin
            rd_mux[cac_pkg::C2_BANK] = bank_ff;
            rd_mux[cac_pkg::C2_PON] = pon_ff;
            rd_mux[cac_pkg::C2_FLAG] = flag_ff && alarm_en; // RL10
         end
         cac_pkg::IDX_IRQ_STS: rd_mux = sts_ff;
         cac_pkg::IDX_IRQ_MSK: rd_mux = msk_ff;
         default: rd_mux = 8'h00;
      endcase
      if (!aligned)
         rd_mux = 8'h00;
   end

   // Read data is captured in the setup phase and stands through the access.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata_ff <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         rdata_ff <= {24'h00_0000, rd_mux};
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_ctrl2_wr;
      wr_en && idx == cac_pkg::IDX_CTRL2;
   endsequence

   sequence s_flag_zero_wr;
      s_ctrl2_wr and !wbyte[cac_pkg::C2_FLAG];
   endsequence

   sequence s_quiet_set;
      !dly_done && !por_set;
   endsequence

   a_flag_off_disabled: assert property (!alarm_en |=> !flag_ff) // RL10
      else $error("Flag set while alarm disabled.");
   a_flag_needs_enable: assert property ($rose(flag_ff) |-> $past(alarm_en)) // RL9
      else $error("Flag rose without enable.");
   a_flag_holds_set: assert property (flag_ff && alarm_en && !flag_clr && !por_set
      |=> flag_ff) // RL11
      else $error("Flag dropped without a clear.");
   a_zero_clears_pin: assert property (s_flag_zero_wr ##0 s_quiet_set ##0 alarm_en
      |=> !flag_ff && !irq_a_pin_oe) // RL12
      else $error("Zero write did not release pin.");
   a_one_write_null: assert property (s_ctrl2_wr ##0 wbyte[cac_pkg::C2_FLAG]
      ##0 !flag_ff ##0 s_quiet_set |=> !flag_ff) // RL12
      else $error("Writing one set the flag.");
   a_por_zeroes: assert property (por_set |=> alm_min_ff == 8'h00 && alm_hour_ff == 8'h00
      && alm_day_ff == 8'h00 && alm_mon_ff == 8'h00) // RL13
      else $error("Power-on did not zero alarms.");
   a_minute_storage: assert property (wr_en && idx == cac_pkg::IDX_ALM_B && !bank_ff
      && !por_set |=> alm_min_ff == $past(wbyte)) // RL1
      else $error("Minute register lost written byte.");
   a_pin_on_flag: assert property ($rose(flag_ff) |-> irq_a_pin_oe
      && $past(dly_done)) // RL14
      else $error("Flag rose without delay end.");
   a_fire_on_edge: assert property (match_edge |=> prev_match_ff) // RL15
      else $error("Match edge was not remembered.");
   a_month_fields: assert property (time_upd && alarm_en && !prev_match_ff
      && alm_mon_ff[cac_pkg::MATCH_EN]
      && ((alm_mon_ff ^ now.month) & cac_pkg::MON_MSK) != 8'h00 |-> !match_edge) // RL8
      else $error("Month mismatch still fired.");
   a_minute_compare: assert property (match |-> // RL1 RL2
      (alm_min_ff & cac_pkg::MIN_MSK) == (now.minute & cac_pkg::MIN_MSK))
      else $error("Match with unequal minutes.");
   a_hour_compare: assert property (match |-> // RL4 RL5
      (alm_hour_ff & cac_pkg::HOUR_MSK) == (now.hour & cac_pkg::HOUR_MSK))
      else $error("Match with unequal hours.");
endmodule // cac_alarm_top

// ### sim/cac_time_src.sv
// Running time counter model that feeds the alarm block.
`timescale 1ns/1ps
module cac_time_src (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic set_stb, // load a new time
   input wire cac_pkg::cac_time_t set_val, // time to load
   output cac_pkg::cac_time_t now, // running counters
   output logic time_upd // one-cycle update pulse
);
   // The update pulse lands in the same cycle as the new counter value.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         now <= 32'h00000000;
         time_upd <= 1'b0;
      end
      else
      begin
         time_upd <= set_stb;
         if (set_stb)
            now <= set_val;
      end
   end
endmodule // cac_time_src

// ### sim/tb_top.sv
// Self-checking bench for the calendar alarm block.
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned D = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic por_set = 1'b0;
   logic ts = 1'b0;
   cac_pkg::cac_time_t tv = 32'h00000000;
   cac_pkg::cac_time_t now;
   logic [31:0] prdata, r;
   logic pready, pslverr, err, time_upd, irq_a_pin_o, irq_a_pin_oe, irq;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   always #2.5 pclk = ~pclk;
   cac_alarm_top #(.DLY_CYCLES(D)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .now(now), .time_upd(time_upd),
      .por_set(por_set), .irq_a_pin_o(irq_a_pin_o), .irq_a_pin_oe(irq_a_pin_oe), .irq(irq));
   cac_time_src u_src (.pclk(pclk), .presetn(presetn), .set_stb(ts), .set_val(tv),
      .now(now), .time_upd(time_upd));
   task results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; it holds the request until pready is sampled high.
   task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 8'h00);
      chk(r, exp);
   endtask
   task upd(input cac_pkg::cac_time_t t);
      @(posedge pclk);
      tv <= t;
      ts <= 1'b1;
      @(posedge pclk);
      ts <= 1'b0;
   endtask
   task expect_fire(input logic e);
      repeat (10) @(posedge pclk);
      chk(32'(irq_a_pin_oe), 32'h00000000);
      repeat (D) @(posedge pclk);
      chk(32'(irq_a_pin_oe), 32'(e));
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         results;
      end
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h2C, 32'h00000000);
      rd(8'h30, 32'h00000000);
      wr(8'h3C, 8'h80);
      wr(8'h2C, 8'hC5);
      rd(8'h2C, 32'h000000C5);
      wr(8'h30, 8'hE9);
      rd(8'h30, 32'h000000E9);
      wr(8'h3C, 8'h00);
      wr(8'h2C, 8'hFF);
      rd(8'h2C, 32'h000000FF);
      wr(8'h30, 8'hC0);
      rd(8'h30, 32'h000000C0);
      pstrb <= 4'h0;
      wr(8'h2C, 8'h00);
      pstrb <= 4'hF;
      rd(8'h2C, 32'h000000FF);
      rd(8'h48, 32'h00000000);
      chk(32'(err), 32'h00000001);
      @(posedge pclk);
      por_set <= 1'b1;
      @(posedge pclk);
      por_set <= 1'b0;
      rd(8'h2C, 32'h00000000);
      rd(8'h30, 32'h00000000);
      wr(8'h2C, 8'h23);
      wr(8'h30, 8'h09);
      wr(8'h3C, 8'h80);
      wr(8'h2C, 8'h83);
      wr(8'h30, 8'h01);
      wr(8'h3C, 8'h00);
      wr(8'h44, 8'h01);
      wr(8'h38, 8'h40);
      upd(32'h05040923);
      expect_fire(1'b0);
      upd(32'h05030922);
      upd(32'h05030923);
      expect_fire(1'b1);
      chk(32'(irq_a_pin_o), 32'h00000000);
      chk(32'(irq), 32'h00000001);
      rd(8'h3C, 32'h00000001);
      wr(8'h3C, 8'h01);
      @(negedge pclk);
      chk(32'(irq_a_pin_oe), 32'h00000001);
      rd(8'h3C, 32'h00000001);
      wr(8'h44, 8'h00);
      @(negedge pclk);
      chk(32'(irq), 32'h00000000);
      wr(8'h44, 8'h01);
      @(negedge pclk);
      chk(32'(irq), 32'h00000001);
      wr(8'h40, 8'h01);
      @(negedge pclk);
      chk(32'(irq), 32'h00000000);
      wr(8'h3C, 8'h00);
      @(negedge pclk);
      chk(32'(irq_a_pin_oe), 32'h00000000);
      rd(8'h3C, 32'h00000000);
      upd(32'h05030922);
      upd(32'h05030923);
      expect_fire(1'b1);
      wr(8'h38, 8'h00);
      rd(8'h3C, 32'h00000000);
      chk(32'(irq_a_pin_oe), 32'h00000000);
      upd(32'h05030923);
      wr(8'h38, 8'h40);
      upd(32'h05030923);
      expect_fire(1'b0);
      upd(32'h05030924);
      upd(32'h05030923);
      expect_fire(1'b1);
      wr(8'h38, 8'h00);
      wr(8'h30, 8'h32);
      wr(8'h3C, 8'h80);
      wr(8'h2C, 8'h03);
      wr(8'h30, 8'h87);
      wr(8'h3C, 8'h00);
      wr(8'h38, 8'h40);
      upd(32'h08153223);
      expect_fire(1'b0);
      upd(32'h07153222);
      upd(32'h07153223);
      expect_fire(1'b1);
      wr(8'h38, 8'h00);
      wr(8'h3C, 8'h80);
      wr(8'h2C, 8'h95);
      wr(8'h3C, 8'h00);
      wr(8'h38, 8'h40);
      upd(32'h07163223);
      expect_fire(1'b0);
      upd(32'h07153223);
      expect_fire(1'b1);
      wr(8'h38, 8'h00);
      wr(8'h3C, 8'h80);
      wr(8'h2C, 8'h55);
      wr(8'h30, 8'h67);
      wr(8'h3C, 8'h00);
      wr(8'h2C, 8'hA3);
      wr(8'h30, 8'hF2);
      wr(8'h38, 8'h40);
      upd(32'h01013222);
      expect_fire(1'b0);
      upd(32'h01013223);
      expect_fire(1'b1);
      results;
   end
endmodule // tb_top
